/* src/gbf_map.svh */
// Byte codes, field positions and sizes of the binary message framer
`ifndef GBF_MAP_SVH
`define GBF_MAP_SVH

// ---------------------------------------------------------------------
// Frame delimiters
// ---------------------------------------------------------------------
`define GBF_SYNC0      8'hA0
`define GBF_SYNC1      8'hA2
`define GBF_END0       8'hB0
`define GBF_END1       8'hB3

// ---------------------------------------------------------------------
// Message identifiers
// ---------------------------------------------------------------------
`define GBF_ID_NAV     8'h02
`define GBF_ID_SAT     8'h43
`define GBF_SUB_SAT    8'h10
`define GBF_ID_CYC     8'h33
`define GBF_SUB_CYC    8'h01
`define GBF_ID_VER     8'h06
`define GBF_ID_POLL    8'h84
`define GBF_ID_OTS     8'h12
`define GBF_ID_ACK     8'h0B
`define GBF_ID_NAK     8'h0C

// ---------------------------------------------------------------------
// Sizes and field positions
// ---------------------------------------------------------------------
`define GBF_NAV_HDR    5'd29
`define GBF_NAV_LEN    16'd47
`define GBF_USED_MAX   8'd18
`define GBF_SAT_HDR    5'd18
`define GBF_REC_BYTES  16'd12
`define GBF_REC_LAST   4'd11
`define GBF_MAX_SATS   8'd15
`define GBF_SHORT_HDR  5'd3
`define GBF_OTS_HDR    5'd2
`define GBF_ST_ACQ     0
`define GBF_ST_EPH     7
`define GBF_ST_USED    15
`define GBF_GPS_LO     8'd1
`define GBF_GPS_HI     8'd32
`define GBF_GLO_LO     8'd65
`define GBF_GLO_HI     8'd88
`define GBF_SBAS_LO    8'd120
`define GBF_SBAS_HI    8'd138
`define GBF_QZA_LO     8'd173
`define GBF_QZA_HI     8'd187
`define GBF_QZB_LO     8'd193
`define GBF_QZB_HI     8'd202

`endif

/* src/gbf_pkg.sv */
// Types shared by the binary message framer
package gbf_pkg;

   // ------------------------------------------------------------------
   // Message kinds and frame sequence
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      K_NAV, K_SAT, K_CYC, K_VER, K_OTS, K_ACK, K_NAK
   } gbf_kind_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_SYNC0, ST_SYNC1, ST_LENH, ST_LENL,
      ST_PAY, ST_CKH, ST_CKL, ST_END0, ST_END1
   } gbf_st_t;

   // ------------------------------------------------------------------
   // Per space_vehicle record and message fields
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  constel;
      logic [4:0]  aux;
      logic [7:0]  id;
      logic [15:0] azim;
      logic [15:0] elev;
      logic [15:0] cn0;
      logic        acq;
      logic        eph;
      logic        used;
   } gbf_rec_t;

   typedef struct packed {
      logic [15:0]        week;
      logic [31:0]        week_time_ms;
      logic signed [31:0] pos_x;
      logic signed [31:0] pos_y;
      logic signed [31:0] pos_z;
      logic signed [15:0] vel_x;
      logic signed [15:0] vel_y;
      logic signed [15:0] vel_z;
      logic [7:0]         horizontal_dilution;
      logic [7:0]         used_cnt;
      logic [3:0]         grp_cnt;
      logic [3:0]         grp_idx;
      logic [7:0]         nsat;
      logic [7:0]         ack_id;
      logic [7:0]         ack_sub;
   } gbf_fields_t;

endpackage

/* src/gbf_framer.sv */
// Binary output message framer: builds, checksums and streams frames
`timescale 1ns/1ps
// How it works
// - Satellite data opens 43 10, week, ms time, eight zero bytes
// - Group byte: message count high nibble, index low nibble
// - Satellite count kept within one to fifteen, then records
// - Record info word top three bits hold constellation code
// - Info bits twelve to eight hold channel or augmentation code
// - Info low byte holds satellite number or slot
// - Azimuth, elevation, carrier-to-noise follow as 2-byte tenths
// - 32-bit status: bit 0 acquired, 7 ephemeris, 15 used
// - Navigation message: id 2, 4-byte positions, 2-byte velocities
// - Then filler, dilution, filler, week, millisecond time
// - Used count up to eighteen, eighteen-entry list zero padded
// - Used list entries outside the legal ranges go out as zero
// - Cycle-complete 33 01 00 sent after the cycle's last message
// - Successful version poll 132 queues version message 6
// - Version message: two lengths, two zero-terminated strings
// - Ok-to-send id 18: zero before sleep, one awake and at start
// - Acknowledge 11 carries request id and sub-id
// - Negative acknowledge 12 carries failed id and sub-id
// - Frame: A0 A2, length, payload, checksum, B0 B3
`include "gbf_map.svh"
module gbf_framer
   import gbf_pkg::*;
#(
   parameter int VER_AW = 6
) (
   // Clock, reset, enable
   input  logic        i_core_clk,
   input  logic        i_rst,
   input  logic        i_ce,
   // Message requests
   input  logic        i_req_valid,
   input  gbf_kind_t   i_req_kind,
   input  logic        i_req_last,
   input  gbf_fields_t i_fields,
   output logic        o_req_ready,
   // Host command outcome
   input  logic        i_cmd_done,
   input  logic        i_cmd_ok,
   input  logic [7:0]  i_cmd_id,
   input  logic [7:0]  i_cmd_sub,
   // Power state events
   input  logic        i_sleep_enter,
   input  logic        i_wake,
   // Table writes
   input  logic        i_rec_wr,
   input  logic [3:0]  i_rec_addr,
   input  gbf_rec_t    i_rec,
   input  logic        i_used_wr,
   input  logic [4:0]  i_used_addr,
   input  logic [7:0]  i_used_id,
   input  logic        i_ver_wr,
   input  logic [VER_AW-1:0] i_ver_addr,
   input  logic [7:0]  i_ver_char,
   input  logic [7:0]  i_ver_vlen,
   input  logic [7:0]  i_ver_clen,
   // Byte stream
   output logic [7:0]  o_tx_data,
   output logic        o_tx_valid,
   input  logic        i_tx_ready,
   output logic        o_busy
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      gbf_st_t                      st;
      gbf_kind_t                    kind;
      gbf_fields_t                  f;
      logic [15:0]                  len;
      logic [7:0]                   pos;
      logic [14:0]                  csum;
      logic [3:0]                   rec_i;
      logic [3:0]                   rb;
      logic [7:0]                   vlen;
      logic [7:0]                   clen;
      logic                         ots_pend;
      logic                         ots_val;
      logic                         ind;
      logic                         ack_pend;
      logic                         aok;
      logic                         ver_pend;
      logic                         cyc_pend;
      logic [7:0]                   aid;
      logic [7:0]                   asub;
      logic [7:0]                   b0;
      logic [7:0]                   b1;
      logic [1:0]                   cnt;
      logic                         vld;
      logic                         rdy;
      logic                         busy;
      gbf_rec_t [14:0]              rec;
      logic [17:0][7:0]             umem;
      logic [2**VER_AW-1:0][7:0]    vmem;
   } gbf_state_t;

   gbf_state_t       s_r;
   gbf_state_t       s_nxt;
   logic             gen_push;
   logic             pop;
   logic [7:0]       gen_byte;
   logic [7:0]       pay_byte;
   logic [7:0]       tail;
   logic [7:0]       ver_tk;
   logic [28:0][7:0] hdr;
   logic [11:0][7:0] recb;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Pack one record into 12 bytes: info word, azimuth, elevation, carrier-to-noise, status word
   function automatic logic [11:0][7:0] rec_bytes(input gbf_rec_t r);
      logic [31:0] stat;
      stat                = 32'h0000_0000;
      stat[`GBF_ST_ACQ]   = r.acq;
      stat[`GBF_ST_EPH]   = r.eph;
      stat[`GBF_ST_USED]  = r.used;
      return {r.constel, r.aux, r.id, r.azim, r.elev, r.cn0, stat};
   endfunction

   function automatic logic id_ok(input logic [7:0] v);
      return (v >= `GBF_GPS_LO  && v <= `GBF_GPS_HI)  ||
             (v >= `GBF_GLO_LO  && v <= `GBF_GLO_HI)  ||
             (v >= `GBF_SBAS_LO && v <= `GBF_SBAS_HI) ||
             (v >= `GBF_QZA_LO  && v <= `GBF_QZA_HI)  ||
             (v >= `GBF_QZB_LO  && v <= `GBF_QZB_HI);
   endfunction

   function automatic logic [4:0] hlen_of(input gbf_kind_t k);
      unique case (k)
         K_NAV:   return `GBF_NAV_HDR;
         K_SAT:   return `GBF_SAT_HDR;
         K_OTS:   return `GBF_OTS_HDR;
         default: return `GBF_SHORT_HDR;
      endcase
   endfunction

   function automatic logic [15:0] len_of(input gbf_kind_t k,
                                          input logic [7:0] nsat,
                                          input logic [7:0] vl,
                                          input logic [7:0] cl);
      unique case (k)
         K_NAV:   return `GBF_NAV_LEN;
         K_SAT:   return 16'(`GBF_SAT_HDR) + `GBF_REC_BYTES * {8'h00, nsat};
         K_VER:   return 16'(`GBF_SHORT_HDR) + {8'h00, vl} + {8'h00, cl};
         K_OTS:   return 16'(`GBF_OTS_HDR);
         default: return 16'(`GBF_SHORT_HDR);
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      s_nxt    = s_r;
      gen_push = (s_r.st != ST_IDLE) && (s_r.cnt != 2'd2);
      pop      = s_r.vld && i_tx_ready;
      gen_byte = 8'h00;
      pay_byte = 8'h00;
      tail     = s_r.pos - {3'd0, hlen_of(s_r.kind)};
      ver_tk   = tail - s_r.vlen;
      recb     = rec_bytes(s_r.rec[s_r.rec_i]);

      // Table writes land at once; rewriting mid-frame tears the frame
      if (i_rec_wr && {4'h0, i_rec_addr} < `GBF_MAX_SATS) begin
         s_nxt.rec[i_rec_addr] = i_rec;
      end
      if (i_used_wr && {3'd0, i_used_addr} < `GBF_USED_MAX) begin
         s_nxt.umem[i_used_addr] = i_used_id;
      end
      if (i_ver_wr) begin
         s_nxt.vmem[i_ver_addr] = i_ver_char;
      end

      // Fixed part of each payload, left aligned
      unique case (s_r.kind)
         K_NAV: hdr = {`GBF_ID_NAV, s_r.f.pos_x, s_r.f.pos_y, s_r.f.pos_z,
                       s_r.f.vel_x, s_r.f.vel_y, s_r.f.vel_z, 8'h00,
                       s_r.f.horizontal_dilution, 8'h00, s_r.f.week,
                       s_r.f.week_time_ms, s_r.f.used_cnt};
         K_SAT: hdr = {`GBF_ID_SAT, `GBF_SUB_SAT, s_r.f.week,
                       s_r.f.week_time_ms, 64'h0, s_r.f.grp_cnt,
                       s_r.f.grp_idx, s_r.f.nsat, 88'h0};
         K_CYC: hdr = {`GBF_ID_CYC, `GBF_SUB_CYC, 8'h00, 208'h0};
         K_VER: hdr = {`GBF_ID_VER, s_r.vlen, s_r.clen, 208'h0};
         K_OTS: hdr = {`GBF_ID_OTS, 7'h00, s_r.ind, 216'h0};
         K_ACK: hdr = {`GBF_ID_ACK, s_r.f.ack_id, s_r.f.ack_sub, 208'h0};
         K_NAK: hdr = {`GBF_ID_NAK, s_r.f.ack_id, s_r.f.ack_sub, 208'h0};
         default: hdr = '0;
      endcase

      if (s_r.pos < {3'd0, hlen_of(s_r.kind)}) begin
         pay_byte = hdr[5'd28 - s_r.pos[4:0]];
      end else if (s_r.kind == K_NAV) begin
         if (tail < s_r.f.used_cnt && id_ok(s_r.umem[tail[4:0]])) begin
            pay_byte = s_r.umem[tail[4:0]];
         end
      end else if (s_r.kind == K_SAT) begin
         pay_byte = recb[`GBF_REC_LAST - s_r.rb];
      end else if (s_r.kind == K_VER) begin
         if (tail < s_r.vlen) begin
            if (tail != s_r.vlen - 8'd1) begin
               pay_byte = s_r.vmem[VER_AW'(tail)];
            end
         end else if (ver_tk != s_r.clen - 8'd1) begin
            pay_byte = s_r.vmem[VER_AW'(s_r.vlen - 8'd1 + ver_tk)];
         end
      end

      // ---------------------------------------------------------------
      // Frame sequence
      // ---------------------------------------------------------------
      // Delimiters and order
      unique case (s_r.st)
         ST_IDLE: gen_byte = 8'h00;
         ST_SYNC0: begin
            gen_byte = `GBF_SYNC0;
            if (gen_push) s_nxt.st = ST_SYNC1;
         end
         ST_SYNC1: begin
            gen_byte = `GBF_SYNC1;
            if (gen_push) s_nxt.st = ST_LENH;
         end
         ST_LENH: begin
            gen_byte = s_r.len[15:8];
            if (gen_push) s_nxt.st = ST_LENL;
         end
         ST_LENL: begin
            gen_byte = s_r.len[7:0];
            if (gen_push) s_nxt.st = ST_PAY;
         end
         ST_PAY: begin
            gen_byte = pay_byte;
            if (gen_push) begin
               s_nxt.csum = s_r.csum + {7'h00, pay_byte};
               s_nxt.pos  = s_r.pos + 8'd1;
               if (s_r.kind == K_SAT && s_r.pos >= {3'd0, `GBF_SAT_HDR}) begin
                  if (s_r.rb == `GBF_REC_LAST) begin
                     s_nxt.rb    = 4'h0;
                     s_nxt.rec_i = s_r.rec_i + 4'h1;
                  end else begin
                     s_nxt.rb = s_r.rb + 4'h1;
                  end
               end
               if ({8'h00, s_r.pos} == s_r.len - 16'd1) s_nxt.st = ST_CKH;
            end
         end
         ST_CKH: begin
            gen_byte = {1'b0, s_r.csum[14:8]};
            if (gen_push) s_nxt.st = ST_CKL;
         end
         ST_CKL: begin
            gen_byte = s_r.csum[7:0];
            if (gen_push) s_nxt.st = ST_END0;
         end
         ST_END0: begin
            gen_byte = `GBF_END0;
            if (gen_push) s_nxt.st = ST_END1;
         end
         ST_END1: begin
            gen_byte = `GBF_END1;
            if (gen_push) s_nxt.st = ST_IDLE;
         end
         default: s_nxt.st = ST_IDLE;
      endcase

      // Two-entry buffer; a stalled receiver halts the sequence above
      if (pop) begin
         s_nxt.b0  = s_r.b1;
         s_nxt.cnt = s_r.cnt - 2'd1;
      end
      if (gen_push) begin
         if (s_nxt.cnt == 2'd0) begin
            s_nxt.b0 = gen_byte;
         end else begin
            s_nxt.b1 = gen_byte;
         end
         s_nxt.cnt = s_nxt.cnt + 2'd1;
      end

      // ---------------------------------------------------------------
      // Frame start, fixed priority among pending messages
      // ---------------------------------------------------------------
      if (s_r.st == ST_IDLE) begin
         s_nxt.pos   = 8'h00;
         s_nxt.csum  = 15'h0000;
         s_nxt.rb    = 4'h0;
         s_nxt.rec_i = 4'h0;
         s_nxt.vlen  = i_ver_vlen;
         s_nxt.clen  = i_ver_clen;
         if (s_r.ots_pend) begin
            s_nxt.kind     = K_OTS;
            s_nxt.ind      = s_r.ots_val;
            s_nxt.ots_pend = 1'b0;
            s_nxt.st       = ST_SYNC0;
         end else if (s_r.ack_pend) begin
            s_nxt.kind      = s_r.aok ? K_ACK : K_NAK;
            s_nxt.f.ack_id  = s_r.aid;
            s_nxt.f.ack_sub = s_r.asub;
            s_nxt.ack_pend  = 1'b0;
            s_nxt.st        = ST_SYNC0;
         end else if (s_r.ver_pend) begin
            s_nxt.kind     = K_VER;
            s_nxt.ver_pend = 1'b0;
            s_nxt.st       = ST_SYNC0;
         end else if (s_r.cyc_pend) begin
            s_nxt.kind     = K_CYC;
            s_nxt.cyc_pend = 1'b0;
            s_nxt.st       = ST_SYNC0;
         end else if (i_req_valid && s_r.rdy) begin
            s_nxt.kind     = i_req_kind;
            s_nxt.f        = i_fields;
            s_nxt.cyc_pend = i_req_last;
            s_nxt.st       = ST_SYNC0;
            if (i_fields.nsat == 8'h00) begin
               s_nxt.f.nsat = 8'h01;
            end else if (i_fields.nsat > `GBF_MAX_SATS) begin
               s_nxt.f.nsat = `GBF_MAX_SATS;
            end
            if (i_fields.used_cnt > `GBF_USED_MAX) begin
               s_nxt.f.used_cnt = `GBF_USED_MAX;
            end
         end
         s_nxt.len = len_of(s_nxt.kind, s_nxt.f.nsat, s_nxt.vlen,
                            s_nxt.clen);
      end

      // Events after the clears, so a same-cycle event is kept
      // Sleep and wake
      if (i_sleep_enter) begin
         s_nxt.ots_pend = 1'b1;
         s_nxt.ots_val  = 1'b0;
      end
      if (i_wake) begin
         s_nxt.ots_pend = 1'b1;
         s_nxt.ots_val  = 1'b1;
      end
      // One outcome is held; a newer one replaces an unsent one
      if (i_cmd_done) begin
         s_nxt.ack_pend = 1'b1;
         s_nxt.aok      = i_cmd_ok;
         s_nxt.aid      = i_cmd_id;
         s_nxt.asub     = i_cmd_sub;
         if (i_cmd_ok && i_cmd_id == `GBF_ID_POLL) s_nxt.ver_pend = 1'b1;
      end

      s_nxt.vld  = s_nxt.cnt != 2'd0;
      s_nxt.busy = s_nxt.st != ST_IDLE;
      s_nxt.rdy  = (s_nxt.st == ST_IDLE) && !s_nxt.ots_pend &&
                   !s_nxt.ack_pend && !s_nxt.ver_pend && !s_nxt.cyc_pend;
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r          <= '0;
         s_r.ots_pend <= 1'b1;
         s_r.ots_val  <= 1'b1;
      end else if (i_ce) begin
         s_r <= s_nxt;
      end
   end

   assign o_tx_data   = s_r.b0;
   assign o_tx_valid  = s_r.vld;
   assign o_req_ready = s_r.rdy;
   assign o_busy      = s_r.busy;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   a_frame_order: assert property (
      (i_ce && gen_push && s_r.st == ST_LENL)
      |=> (s_r.st == ST_PAY && s_r.pos == 8'h00))
      else $error("payload did not follow the length bytes");

   a_cksum_msb: assert property (
      (gen_push && s_r.st == ST_CKH)
      |-> (!gen_byte[7] && gen_byte[6:0] == s_r.csum[14:8]))
      else $error("checksum high byte wrong");

   a_len_msb: assert property (
      (i_ce && gen_push && s_r.st == ST_LENH)
      |=> (s_r.st == ST_LENL &&
           (s_r.cnt == 2'd1 ? s_r.b0 : s_r.b1) == s_r.len[15:8]))
      else $error("length high byte not queued");

   a_startup_ots: assert property (
      (i_ce && s_r.st == ST_IDLE && s_r.ots_pend)
      |=> (s_r.kind == K_OTS && s_r.ind == $past(s_r.ots_val)))
      else $error("pending ok-to-send not sent first");

   a_poll_version: assert property (
      (i_ce && i_cmd_done && i_cmd_ok && i_cmd_id == `GBF_ID_POLL)
      |=> (s_r.ver_pend && s_r.ack_pend))
      else $error("version poll not queued");

   a_nsat_range: assert property (
      (s_r.busy && s_r.kind == K_SAT)
      |-> (s_r.f.nsat >= 8'd1 && s_r.f.nsat <= `GBF_MAX_SATS))
      else $error("satellite count out of range");

   a_used_pad: assert property (
      (gen_push && s_r.st == ST_PAY && s_r.kind == K_NAV &&
       s_r.pos >= 8'(`GBF_NAV_HDR) + s_r.f.used_cnt)
      |-> (gen_byte == 8'h00))
      else $error("unused list entry not zero");

   a_status_resv: assert property (
      (gen_push && s_r.st == ST_PAY && s_r.kind == K_SAT &&
       s_r.pos >= 8'(`GBF_SAT_HDR) && s_r.rb >= 4'd8 && s_r.rb <= 4'd9)
      |-> (gen_byte == 8'h00))
      else $error("reserved status bits not zero");

   a_cyc_after: assert property (
      (i_ce && s_r.st == ST_IDLE && s_r.cyc_pend && !s_r.ots_pend &&
       !s_r.ack_pend && !s_r.ver_pend)
      |=> (s_r.kind == K_CYC && s_r.st == ST_SYNC0))
      else $error("cycle-complete not started");

   a_buf_hold: assert property (
      (s_r.vld && !i_tx_ready) |=> (o_tx_valid && $stable(o_tx_data)))
      else $error("stalled byte lost");

endmodule

/* verif/gbf_host.sv */
// Host reader model: takes stream bytes with random stalls
`timescale 1ns/1ps
module gbf_host (
   input  wire logic       i_clk,
   input  wire logic       i_ce,
   input  wire logic       i_stall,
   input  wire logic       i_valid,
   input  wire logic [7:0] i_data,
   output logic            o_ready,
   output int              o_frames
);
   logic [7:0]  last_r;
   logic [15:0] len_r;
   logic [14:0] sum_r;
   logic [15:0] ck_r;
   int          pos_r;
   // Stalls off the sampling edge
   always @(negedge i_clk) o_ready <= !i_stall || ($urandom % 3 != 0);
   // Walk each frame by its length, ends on B0 B3
   // Frames with a wrong checksum are dropped, not counted
   always @(posedge i_clk) if (i_valid === 1'b1 && o_ready && i_ce) begin
      last_r <= i_data;
      pos_r  <= pos_r + 1;
      if (pos_r == 0 && i_data != 8'hA0) pos_r <= 0;
      if (pos_r == 1 && i_data != 8'hA2) pos_r <= 0;
      if (pos_r == 2) len_r[15:8] <= i_data;
      if (pos_r == 3) len_r[7:0] <= i_data;
      if (pos_r < 4) sum_r <= '0;
      else if (pos_r < len_r + 4) sum_r <= sum_r + 15'(i_data);
      if (pos_r == len_r + 4) ck_r[15:8] <= i_data;
      if (pos_r == len_r + 5) ck_r[7:0] <= i_data;
      if (pos_r > 3 && pos_r == len_r + 7) begin
         pos_r <= 0;
         if (last_r == 8'hB0 && i_data == 8'hB3 && ck_r == {1'b0, sum_r})
            o_frames <= o_frames + 1;
      end
   end
endmodule

/* verif/testbench.sv */
// Bench: byte-exact frame model checked against the framer
`timescale 1ns/1ps
module testbench;
   import gbf_pkg::*;
   logic clk, rst, valid, last, done, ok, slp, wk, rw, uw, vw, stall;
   logic ce, cez;
   logic [7:0] cid, csub, uid, vch, vl, cl, txd, pl[$], ex[$];
   logic [3:0] ra, va;
   logic [4:0] ua;
   logic [95:0] r;
   logic txv, rdy, rr, busy;
   gbf_kind_t kind;
   gbf_fields_t f, fn, fs;
   gbf_rec_t rec, rs[3];
   int fails, checked, nf, fr;
   logic [7:0] ul[18] = '{1, 32, 33, 64, 65, 88, 89, 119, 120, 138, 139,
                          172, 173, 187, 188, 193, 203, 202};
   gbf_framer #(.VER_AW(4)) dut_u (.i_core_clk(clk), .i_rst(rst),
      .i_ce(ce), .i_req_valid(valid), .i_req_kind(kind),
      .i_req_last(last), .i_fields(f), .o_req_ready(rr),
      .i_cmd_done(done), .i_cmd_ok(ok), .i_cmd_id(cid), .i_cmd_sub(csub),
      .i_sleep_enter(slp), .i_wake(wk), .i_rec_wr(rw), .i_rec_addr(ra),
      .i_rec(rec), .i_used_wr(uw), .i_used_addr(ua), .i_used_id(uid),
      .i_ver_wr(vw), .i_ver_addr(va), .i_ver_char(vch), .i_ver_vlen(vl),
      .i_ver_clen(cl), .o_tx_data(txd), .o_tx_valid(txv),
      .i_tx_ready(rdy), .o_busy(busy));
   gbf_host host_u (.i_clk(clk), .i_ce(ce), .i_stall(stall),
      .i_valid(txv), .i_data(txd), .o_ready(rdy), .o_frames(fr));
   // Random enable gaps only once cez is raised
   always @(negedge clk) ce <= !cez || ($urandom % 4 != 0);
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   task test_done;
      if (fails == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task tick;
      @(negedge clk);
   endtask
   task p(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) pl.push_back(v[8*i +: 8]);
   endtask
   // sum kept to 15 bits, MSB first
   task frame;
      logic [15:0] s;
      s = 0;
      foreach (pl[i]) s += pl[i];
      s[15] = 1'b0;
      nf++;
      ex = {ex, 8'hA0, 8'hA2, 8'(pl.size() >> 8), 8'(pl.size()), pl,
            s[15:8], s[7:0], 8'hB0, 8'hB3};
      pl = {};
   endtask
   task cmp(input logic [7:0] g);
      checked++;
      if (ex.size() == 0 || g !== ex[0]) begin
         fails++;
         $display("mismatch %0t byte %h", $time, g);
      end
      if (ex.size() > 0) void'(ex.pop_front());
   endtask
   always @(posedge clk) if (txv === 1'b1 && rdy && ce) cmp(txd);
   task cmpn(input int g, input int e);
      checked++;
      if (g != e) begin
         fails++;
         $display("mismatch %0t frame count %0d", $time, g);
      end
   endtask
   task limit(input int n);
      if (n >= 9000) begin
         fails++;
         $display("mismatch %0t timeout", $time);
         test_done;
      end
   endtask
   task drain;
      int n;
      for (n = 0; n < 9000 && (ex.size() > 0 || busy !== 1'b0); n++) tick;
      limit(n);
   endtask
   task req(input gbf_kind_t k, input gbf_fields_t v, input logic l);
      int n;
      for (n = 0; n < 9000 && rr !== 1'b1; n++) tick;
      limit(n);
      kind = k; f = v; last = l; valid = 1;
      // Held until an enabled edge takes it
      for (n = 0; n < 9000 && rr === 1'b1; n++) tick;
      valid = 0;
      limit(n);
   endtask
   task cmd(input logic o);
      ok = o; done = 1; tick; done = 0;
   endtask
   function automatic logic lg(logic [7:0] v);
      return (v >= 1 && v <= 32) || (v >= 65 && v <= 88) ||
             (v >= 120 && v <= 138) || (v >= 173 && v <= 187) ||
             (v >= 193 && v <= 202);
   endfunction
   task nav_ex(input gbf_fields_t v, input int u);
      p(2, 1); p(v.pos_x, 4); p(v.pos_y, 4); p(v.pos_z, 4);
      p(v.vel_x, 2); p(v.vel_y, 2); p(v.vel_z, 2);
      p({8'h0, v.horizontal_dilution, 8'h0}, 3);
      p(v.week, 2); p(v.week_time_ms, 4); p(u, 1);
      for (int i = 0; i < 18; i++) p((i < u && lg(ul[i])) ? ul[i] : 0, 1);
      frame;
   endtask
   task sat_ex(input gbf_fields_t v, input int n);
      gbf_rec_t e;
      p(16'h4310, 2); p(v.week, 2); p(v.week_time_ms, 4); p(0, 4);
      p(0, 4); p({v.grp_cnt, v.grp_idx, 8'(n)}, 2);
      for (int i = 0; i < n; i++) begin
         e = '0;
         if (i < 3) e = rs[i];
         p({e.constel, e.aux, e.id, e.azim}, 4);
         p({e.elev, e.cn0}, 4);
         p({16'h0, e.used, 7'h0, e.eph, 6'h0, e.acq}, 4);
      end
      frame;
   endtask
   initial begin
      {valid, last, done, ok, slp, wk, rw, uw, vw, stall, cez} = 0;
      {cid, csub, uid, vch, vl, cl, ra, va, ua} = 0;
      kind = K_NAV; f = 0; fn = 0; rec = 0; rst = 1;
      void'($urandom(13613));
      p(16'h1201, 2); frame;
      repeat (12) tick;
      rst = 0;
      drain;
      stall = 1;
      for (int i = 0; i < 3; i++) begin
         va = 4'(i); vch = 8'h61 + 8'(i); vw = 1; tick;
      end
      vw = 0; vl = 3; cl = 2; cid = 8'h84; csub = 0;
      p(24'h0B8400, 3); frame;
      p(32'h06030261, 4); p(32'h62006300, 4); frame;
      cmd(1);
      drain;
      cid = 8'($urandom); csub = 8'($urandom);
      p({8'h0C, cid, csub}, 3); frame;
      cmd(0);
      drain;
      p(16'h1200, 2); frame;
      slp = 1; tick; slp = 0;
      drain;
      p(16'h1201, 2); frame;
      wk = 1; tick; wk = 0;
      p(24'h330100, 3); frame;
      req(K_CYC, fn, 0);
      drain;
      for (int i = 0; i < 18; i++) begin
         ua = 5'(i); uid = ul[i]; uw = 1; tick;
      end
      uw = 0;
      for (int i = 0; i < 3; i++) begin
         r = {$urandom, $urandom, $urandom};
         rs[i] = r[66:0]; rs[i].constel = 3'(i);
         ra = 4'(i); rec = rs[i]; rw = 1; tick;
      end
      rw = 0;
      for (int i = 0; i < 30; i++) fn[i*8 +: 8] = 8'($urandom);
      fn.used_cnt = 17; fs = fn; fs.nsat = 3;
      nav_ex(fn, 17);
      sat_ex(fs, 3);
      p(24'h330100, 3); frame;
      cez = 1;
      req(K_NAV, fn, 0);
      req(K_SAT, fs, 1);
      fn.used_cnt = 8'hC8; fs.nsat = 8'h14;
      nav_ex(fn, 18);
      sat_ex(fs, 15);
      req(K_NAV, fn, 0);
      req(K_SAT, fs, 0);
      fs.nsat = 8'h00;
      sat_ex(fs, 1);
      req(K_SAT, fs, 0);
      drain;
      cmpn(fr, nf);
      test_done;
   end
endmodule
